//--- design/flash_ssp_pkg.sv
// Purpose: constants and types of the flash self-programming controller
// Assumes: 32-bit AHB-Lite register access, one 40 MHz clock
// Notes:   byte address of a register is four times its index
package flash_selfprog_pkg;

  // register indices
  localparam logic [7:0] IDX_OP_SELECT  = 8'hf2;
  localparam logic [7:0] IDX_KEY_ONE    = 8'hf3;
  localparam logic [7:0] IDX_KEY_TWO    = 8'hf4;
  localparam logic [7:0] IDX_KEY_THREE  = 8'hf5;
  localparam logic [7:0] IDX_KEY_FOUR   = 8'hf6;
  localparam logic [7:0] IDX_PAGE       = 8'hf7;
  localparam logic [7:0] IDX_STATUS     = 8'hf8;
  localparam logic [7:0] IDX_OFFSET_LOW = 8'hfb;
  localparam logic [7:0] IDX_DATA       = 8'hfc;

  localparam int        ADDR_LSB     = 2;
  localparam int        IDX_MSB      = 9;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [3:0] KEY_RESET   = 4'h0;

  // operation codes
  localparam logic [7:0] OP_ERASE = 8'he6;
  localparam logic [7:0] OP_WRITE = 8'h6e;

  // key values, fourth to first, first key in the low nibble
  localparam int         NUM_KEYS = 4;
  localparam logic [15:0] KEY_VALUES = 16'h69a5;

  // page register fields
  localparam int         SECT_MSB     = 7;
  localparam int         SECT_LSB     = 2;
  localparam int         SECT_W       = 6;
  localparam logic [5:0] SECT_LAST    = 6'h0f;
  localparam int         OFF_HI_MSB   = 1;
  localparam int         OFF_W        = 10;
  localparam int         SECTOR_BYTES = 1024;

  // status register fields
  localparam int ST_STATE_MSB = 2;
  localparam int ST_BUSY_BIT  = 3;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  typedef enum logic [2:0] { S0, S1, S2, S3, S4 } unlock_e;

  typedef struct packed {
    logic             erase;
    logic             write;
    logic [SECT_W-1:0] sector;
    logic [OFF_W-1:0]  offset;
    logic [7:0]        data;
  } flash_req_s;

endpackage

//--- design/key_stage.sv
// Purpose: one unlock key nibble register
// Assumes: writes come from the bus slave as one-cycle strobes
// Notes:   a forced clear beats a write in the same cycle
`timescale 1ns/1ps
module key_stage
  import flash_selfprog_pkg::*;
#(
  parameter logic [3:0] KEY = 4'h0
)
(
  // clock and resets
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       wdt_rst,
  // write and clear
  input  wire logic       wr_en,
  input  wire logic [3:0] wdata,
  input  wire logic       force_clr,
  // state
  output logic      [3:0] value_r,
  output logic            match
);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      value_r <= KEY_RESET;
    else if (wdt_rst || force_clr)
      value_r <= KEY_RESET;
    else if (wr_en)
      value_r <= wdata;
  end

  assign match = (value_r == KEY);

endmodule

//--- design/flash_launch.sv
// Purpose: issues one flash request and holds the processor idle
// Assumes: flash array answers each request with one done pulse
// Notes:   a start while busy is dropped
`timescale 1ns/1ps
module flash_launch
  import flash_selfprog_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // request from the unlock logic
  input  wire logic       start,
  input  wire flash_req_s req,
  // flash array side
  input  wire logic       flash_done,
  output flash_req_s      flash_req_r,
  output logic            busy_r
);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flash_req_r <= '0;
    else if (start && !busy_r)
      flash_req_r <= req;
    else
    begin
      flash_req_r.erase <= 1'b0;
      flash_req_r.write <= 1'b0;
    end
  end

  // cpu stays idle until the array reports completion
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_r <= 1'b0;
    else if (start && !busy_r)
      busy_r <= 1'b1;
    else if (flash_done)
      busy_r <= 1'b0;
  end

endmodule

//--- design/flash_ssp_ctrl.sv
// Purpose: register file, unlock sequencer and launch of flash erase/write
// Assumes: single-word AHB-Lite transfers, one slave on the bus
// Notes:   reads take one wait state, writes none
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module flash_selfprog_ctrl
  import flash_selfprog_pkg::*;
(
  // clock and resets
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              wdt_rst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // flash array
  input  wire logic              flash_done,
  output logic                   flash_erase_req,
  output logic                   flash_write_req,
  output logic      [SECT_W-1:0] flash_sector,
  output logic      [OFF_W-1:0]  flash_offset,
  output logic      [7:0]        flash_wdata,
  // processor
  output logic                   cpu_hold
);

  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[ADDR_LSB-1:0] == '0) && (a[31:IDX_MSB+1] == '0)
          && (a[IDX_MSB:ADDR_LSB] == idx);
  endfunction

  logic [7:0]  op_r;
  logic [7:0]  page_r;
  logic [7:0]  offset_r;
  logic [7:0]  data_r;
  logic [31:0] wr_addr_r;
  logic        wr_pend_r;
  logic [31:0] rd_addr_r;
  logic        rd_pend_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  unlock_e     state_r;
  unlock_e     state_nxt;
  logic [3:0]  key_val [NUM_KEYS];
  logic        key_match [NUM_KEYS];
  logic        key_wr [NUM_KEYS];
  logic        key_clr [NUM_KEYS];
  logic        fire;
  logic        op_valid;
  logic        sect_ok;
  logic        busy;
  flash_req_s  req;
  flash_req_s  flash_req_r;
  logic        accept;
  logic        unused_bits;

  assign accept = hsel && hready && htrans[1];
  assign unused_bits = ^hsize;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else
    begin
      wr_pend_r <= accept && hwrite;
      if (accept)
        wr_addr_r <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_pend_r <= 1'b0;
      rd_addr_r <= '0;
    end
    else
    begin
      rd_pend_r <= accept && !hwrite;
      if (accept && !hwrite)
        rd_addr_r <= haddr;
    end
  end

  // one wait state on reads so data reflect the preceding write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout_r <= 1'b1;
    else if (accept && !hwrite)
      hreadyout_r <= 1'b0;
    else
      hreadyout_r <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= '0;
    else if (rd_pend_r && !hreadyout_r)
    begin
      hrdata_r <= '0;
      if (hit(rd_addr_r, IDX_OP_SELECT))
        hrdata_r[7:0] <= op_r;
      if (hit(rd_addr_r, IDX_KEY_ONE))
        hrdata_r[3:0] <= key_val[0];
      if (hit(rd_addr_r, IDX_KEY_TWO))
        hrdata_r[3:0] <= key_val[1];
      if (hit(rd_addr_r, IDX_KEY_THREE))
        hrdata_r[3:0] <= key_val[2];
      if (hit(rd_addr_r, IDX_KEY_FOUR))
        hrdata_r[3:0] <= key_val[3];
      if (hit(rd_addr_r, IDX_PAGE))
        hrdata_r[7:0] <= page_r;
      if (hit(rd_addr_r, IDX_OFFSET_LOW))
        hrdata_r[7:0] <= offset_r;
      if (hit(rd_addr_r, IDX_DATA))
        hrdata_r[7:0] <= data_r;
      if (hit(rd_addr_r, IDX_STATUS))
      begin
        hrdata_r[ST_STATE_MSB:0] <= state_r;
        hrdata_r[ST_BUSY_BIT]    <= busy;
      end
    end
  end

  // plain registers; watchdog reset clears them like hardware reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_r     <= REG_RESET;
      page_r   <= REG_RESET;
      offset_r <= REG_RESET;
      data_r   <= REG_RESET;
    end
    else if (wdt_rst)
    begin
      op_r     <= REG_RESET;
      page_r   <= REG_RESET;
      offset_r <= REG_RESET;
      data_r   <= REG_RESET;
    end
    else if (wr_pend_r)
    begin
      if (hit(wr_addr_r, IDX_OP_SELECT))
        op_r <= hwdata[7:0];
      if (hit(wr_addr_r, IDX_PAGE))
        page_r <= hwdata[7:0];
      if (hit(wr_addr_r, IDX_OFFSET_LOW))
        offset_r <= hwdata[7:0];
      if (hit(wr_addr_r, IDX_DATA))
        data_r <= hwdata[7:0];
    end
  end

  // key chain: each stage cleared when any earlier key mismatches
  genvar k;
  generate
    for (k = 0; k < NUM_KEYS; k++)
    begin : g_key
      if (k == 0)
      begin : g_first
        assign key_clr[k] = fire;
      end
      else
      begin : g_later
        assign key_clr[k] = fire || !key_match[k-1] || key_clr[k-1];
      end
      assign key_wr[k] = wr_pend_r
                         && hit(wr_addr_r, IDX_KEY_ONE + 8'(k));
      key_stage #(
        .KEY (KEY_VALUES[4*k +: 4])
      ) u_key (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .wdt_rst   (wdt_rst),
        .wr_en     (key_wr[k]),
        .wdata     (hwdata[3:0]),
        .force_clr (key_clr[k]),
        .value_r   (key_val[k]),
        .match     (key_match[k])
      );
    end
  endgenerate

  // unlock state follows the key chain; S4 consumed after one cycle
  always_comb
  begin
    state_nxt = S0;
    case (state_r)
      S4:
        state_nxt = S0;
      default:
        if (!key_match[0])
          state_nxt = S0;
        else if (!key_match[1])
          state_nxt = S1;
        else if (!key_match[2])
          state_nxt = S2;
        else if (!key_match[3])
          state_nxt = S3;
        else
          state_nxt = S4;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= S0;
    else if (wdt_rst)
      state_r <= S0;
    else
      state_r <= state_nxt;
  end

  assign fire     = (state_r == S4);
  assign op_valid = (op_r == OP_ERASE) || (op_r == OP_WRITE);
  // reserved sectors abort like a bad code
  assign sect_ok  = (page_r[SECT_MSB:SECT_LSB] <= SECT_LAST);

  always_comb
  begin
    req        = '0;
    req.erase  = (op_r == OP_ERASE) && sect_ok;
    req.write  = (op_r == OP_WRITE) && sect_ok;
    req.sector = page_r[SECT_MSB:SECT_LSB];
    req.offset = {page_r[OFF_HI_MSB:0], offset_r};
    req.data   = data_r;
  end

  // a fire without valid code or sector only clears keys: abort
  flash_launch u_launch (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .start       (fire && op_valid && sect_ok),
    .req         (req),
    .flash_done  (flash_done),
    .flash_req_r (flash_req_r),
    .busy_r      (busy)
  );

  assign hrdata          = hrdata_r;
  assign hreadyout       = hreadyout_r;
  assign hresp           = 1'b0;
  assign flash_erase_req = flash_req_r.erase;
  assign flash_write_req = flash_req_r.write;
  assign flash_sector    = flash_req_r.sector;
  assign flash_offset    = flash_req_r.offset;
  assign flash_wdata     = flash_req_r.data;
  assign cpu_hold        = busy;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || wdt_rst);

  property p_erase;
    fire && op_r == OP_ERASE && sect_ok && !busy
      |=> flash_erase_req && !flash_write_req && cpu_hold;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not issued");

  property p_write;
    fire && op_r == OP_WRITE && sect_ok && !busy
      |=> flash_write_req && !flash_erase_req
          && flash_wdata == $past(data_r);
  endproperty
  a_write: assert property (p_write) else $error("write not issued");

  property p_bad_op;
    fire && !op_valid |=> !flash_erase_req && !flash_write_req;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("bad code launched");

  property p_reserved;
    fire && !sect_ok |=> !flash_erase_req && !flash_write_req;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved sector launched");

  property p_s1;
    state_r != S4 && key_match[0] && !key_match[1] |=> state_r == S1;
  endproperty
  a_s1: assert property (p_s1) else $error("S1 not reached");

  property p_s0;
    !key_match[0] |=> state_r == S0;
  endproperty
  a_s0: assert property (p_s0) else $error("left S0 on bad key");

  property p_s4;
    state_r != S4 && key_match[0] && key_match[1] && key_match[2]
      && key_match[3] |=> state_r == S4 ##1 state_r == S0;
  endproperty
  a_s4: assert property (p_s4) else $error("S4 not taken once");

  property p_chain;
    key_val[0] != KEY_VALUES[3:0]
      |=> key_val[1] == KEY_RESET && key_val[2] == KEY_RESET
          && key_val[3] == KEY_RESET;
  endproperty
  a_chain: assert property (p_chain) else $error("later key kept");

  property p_offset;
    $rose(flash_write_req)
      |-> flash_offset[7:0] == $past(offset_r)
          && flash_offset[OFF_W-1:8] == $past(page_r[OFF_HI_MSB:0])
          && flash_sector == $past(page_r[SECT_MSB:SECT_LSB]);
  endproperty
  a_offset: assert property (p_offset) else $error("bad target");

  property p_hold;
    $rose(cpu_hold) |-> (flash_erase_req || flash_write_req)
      ##1 (cpu_hold && !flash_erase_req && !flash_write_req);
  endproperty
  a_hold: assert property (p_hold) else $error("hold not kept");

endmodule

//--- verif/flash_array_model.sv
// Purpose: behavioural flash array answering erase and write requests
// Assumes: requests arrive as one-cycle pulses
// Notes:   finishes a fixed number of cycles after each request
`timescale 1ns/1ps
module flash_array_model
#(
  parameter int LAT = 20
)
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // request and completion
  input  wire logic erase_req,
  input  wire logic write_req,
  output logic      flash_done
);
  int cnt_r;

  // slow on purpose so the hold can be seen from the bus
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r      <= 0;
      flash_done <= 1'b0;
    end
    else
    begin
      flash_done <= (cnt_r == 1);
      if (erase_req || write_req)
        cnt_r <= LAT;
      else if (cnt_r != 0)
        cnt_r <= cnt_r - 1;
    end
  end
endmodule

//--- verif/tb_top.sv
// Purpose: bus-driven test of the flash self-programming controller
// Assumes: one wait state on reads, none on writes
// Notes:   expectations come from the key and operation codes
`timescale 1ns/1ps
module tb_top
  import flash_selfprog_pkg::*;
;
  logic              hclk;
  logic              hresetn;
  logic              wdt_rst;
  logic              hsel;
  logic              hwrite;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              hreadyout;
  logic              hresp;
  logic              flash_done;
  logic              flash_erase_req;
  logic              flash_write_req;
  logic              cpu_hold;
  logic [SECT_W-1:0] flash_sector;
  logic [OFF_W-1:0]  flash_offset;
  logic [7:0]        flash_wdata;
  logic [1:0]        kind_r;
  logic [31:0]       rv;
  int                miscompares;
  int                checks;
  int                n_req;

  flash_selfprog_ctrl u_flash_selfprog_ctrl (
    .hclk(hclk), .hresetn(hresetn), .wdt_rst(wdt_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .flash_done(flash_done), .flash_erase_req(flash_erase_req),
    .flash_write_req(flash_write_req), .flash_sector(flash_sector),
    .flash_offset(flash_offset), .flash_wdata(flash_wdata),
    .cpu_hold(cpu_hold)
  );

  flash_array_model #(.LAT(20)) u_flash_array_model (
    .hclk(hclk), .hresetn(hresetn), .erase_req(flash_erase_req),
    .write_req(flash_write_req), .flash_done(flash_done)
  );

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // request pulses are counted and their kind kept for later compare
  always @(posedge hclk)
  begin
    if (flash_erase_req || flash_write_req)
    begin
      n_req <= n_req + 1;
      kind_r <= {flash_erase_req, flash_write_req};
    end
  end

  task automatic summarize;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic bus(input logic [7:0] idx, input logic w,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ_BIT;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    bus(idx, 1'b0, 32'h0);
    chk(rv, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // loads target first, then the control registers in order
  task automatic launch(input logic [7:0] op, input logic [7:0] pg,
                        input logic [7:0] off, input logic [7:0] dat);
    logic go;
    int   n0;
    int   k;
    go = (op == OP_ERASE || op == OP_WRITE) && pg[7:2] <= SECT_LAST;
    n0 = n_req;
    wr(IDX_PAGE, {24'h0, pg});
    wr(IDX_OFFSET_LOW, {24'h0, off});
    wr(IDX_DATA, {24'h0, dat});
    wr(IDX_OP_SELECT, {24'h0, op});
    wr(IDX_KEY_ONE, 32'h5);
    wr(IDX_KEY_TWO, 32'ha);
    wr(IDX_KEY_THREE, 32'h9);
    wr(IDX_KEY_FOUR, 32'h6);
    k = 0;
    while (n_req == n0 && k < 8)
    begin
      @(posedge hclk);
      k++;
    end
    chk(n_req - n0, {31'h0, go});
    if (go)
    begin
      chk(kind_r, {op == OP_ERASE, op == OP_WRITE});
      chk(flash_sector, pg[7:2]);
      chk(flash_offset, {pg[1:0], off});
      if (op == OP_WRITE)
        chk(flash_wdata, dat);
      chk(cpu_hold, 1'b1);
      rd(IDX_STATUS, 32'h8);
      k = 0;
      while (cpu_hold === 1'b1 && k < 40)
      begin
        @(posedge hclk);
        k++;
      end
      chk(cpu_hold, 1'b0);
    end
    rd(IDX_STATUS, 32'h0);
    rd(IDX_KEY_ONE, 32'h0);
  endtask

  initial
  begin
    logic [7:0] idxs [6];
    hresetn = 1'b0;
    wdt_rst = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    miscompares = 0;
    checks = 0;
    n_req = 0;
    kind_r = 2'h0;
    idxs = '{IDX_OP_SELECT, IDX_KEY_ONE, IDX_PAGE, IDX_OFFSET_LOW,
             IDX_DATA, IDX_STATUS};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (idxs[i])
      rd(idxs[i], 32'h0);
    wr(8'hf9, 32'h77);
    rd(8'hf9, 32'h0);
    wr(IDX_DATA, 32'h5c);
    rd(IDX_DATA, 32'h5c);
    wr(IDX_KEY_ONE, 32'hf5);
    rd(IDX_KEY_ONE, 32'h5);
    wr(IDX_KEY_TWO, 32'h3);
    rd(IDX_STATUS, 32'h1);
    wr(IDX_KEY_TWO, 32'ha);
    rd(IDX_STATUS, 32'h2);
    wr(IDX_KEY_THREE, 32'h9);
    rd(IDX_STATUS, 32'h3);
    wr(IDX_KEY_FOUR, 32'h2);
    rd(IDX_STATUS, 32'h3);
    wr(IDX_KEY_ONE, 32'h7);
    rd(IDX_KEY_TWO, 32'h0);
    rd(IDX_KEY_THREE, 32'h0);
    rd(IDX_STATUS, 32'h0);
    launch(OP_ERASE, 8'h3f, 8'hff, 8'h00);
    launch(OP_WRITE, 8'h16, 8'h34, 8'h5c);
    launch(OP_WRITE, 8'h00, 8'h00, 8'ha5);
    launch(8'h00, 8'h04, 8'h01, 8'h11);
    launch(8'he7, 8'h04, 8'h01, 8'h11);
    launch(OP_ERASE, 8'h40, 8'h00, 8'h00);
    launch(OP_WRITE, 8'hfc, 8'h00, 8'h22);
    wr(IDX_PAGE, 32'h9d);
    rd(IDX_PAGE, 32'h9d);
    wdt_rst <= 1'b1;
    @(posedge hclk);
    wdt_rst <= 1'b0;
    @(posedge hclk);
    foreach (idxs[i])
      rd(idxs[i], 32'h0);
    summarize();
  end
endmodule
